// >>> common/spb_pkg.sv
// Shared constants and types for the serial bus base configuration fields
package spb_pkg;
    // Clock, long bus reset and strap timing
    localparam int unsigned CLK_MHZ = 25;
    localparam int unsigned LONG_RESET_US = 166;
    localparam int unsigned LONG_RESET_CYCLES = LONG_RESET_US * CLK_MHZ;
    localparam int unsigned STRAP_WAIT = 3;

    // Register offsets
    localparam logic [2:0] REG_ID_OFS = 3'h0;
    localparam logic [2:0] REG_CTRL_OFS = 3'h1;
    localparam logic [2:0] REG_CAPA_OFS = 3'h2;
    localparam logic [2:0] REG_PHYC_OFS = 3'h3;
    localparam logic [2:0] REG_LINK_OFS = 3'h4;

    // Field positions
    localparam int ID_ADDR_LSB = 2;
    localparam int ID_ROOT_BIT = 1;
    localparam int ID_POWER_BIT = 0;
    localparam int CTRL_ROOTNEXT_BIT = 7;
    localparam int CTRL_LONGRST_BIT = 6;
    localparam int CTRL_GAP_LSB = 0;
    localparam int CAPA_EXT_LSB = 5;
    localparam int CAPA_PORTS_LSB = 0;
    localparam int PHYC_SPEED_LSB = 5;
    localparam int PHYC_DELAY_LSB = 0;
    localparam int LINK_ACTIVE_BIT = 7;
    localparam int LINK_CONT_BIT = 6;
    localparam int LINK_JIT_LSB = 3;

    // Fixed codes and reset values
    localparam logic [2:0] EXT_SET_CODE = 3'h7;
    localparam logic [3:0] NUM_PORTS_CODE = 4'h3;
    localparam logic [2:0] SPEED_CODE = 3'h2;
    localparam logic [3:0] DELAY_CODE = 4'h0;
    localparam logic [2:0] JITTER_CODE = 3'h0;
    localparam logic [5:0] GAP_RESET = 6'h3F;
    localparam logic LINK_ACTIVE_RESET = 1'b1;

    // Gap derived timing, cycles = base + gap * step
    localparam logic [11:0] FAIR_BASE = 12'h004;
    localparam logic [11:0] FAIR_STEP = 12'h002;
    localparam logic [11:0] ARST_BASE = 12'h008;
    localparam logic [11:0] ARST_STEP = 12'h004;
    localparam logic [11:0] DLY_BASE = 12'h002;
    localparam logic [11:0] DLY_STEP = 12'h001;

    // Pin indices in the synchroniser
    localparam int PIN_POWER = 0;
    localparam int PIN_LPS = 1;
    localparam int PIN_CONT = 2;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } spb_bus_t;

    typedef struct packed {
        logic bus_reset;
        logic selfid_done;
        logic [5:0] node_address;
        logic tree_root;
        logic cfg_gap_valid;
        logic [5:0] cfg_gap;
        logic traffic_busy;
    } spb_core_evt_t;

    typedef enum logic [2:0] {
        LR_IDLE = 3'b001,
        LR_WAIT = 3'b010,
        LR_DRIVE = 3'b100
    } spb_lr_state_t;

    typedef struct packed {
        logic [2:0] s1;
        logic [2:0] s2;
        logic [2:0] s3;
        logic [2:0] filt;
    } spb_sync_t;

    typedef struct packed {
        spb_sync_t sync;
        logic [5:0] node_address;
        logic addr_valid;
        logic root;
        logic want_root_next;
        logic long_reset_request;
        logic [5:0] gap;
        logic gap_reset_seen;
        logic link_active;
        logic contender;
        logic strap_done;
        logic [1:0] strap_cnt;
        spb_lr_state_t lr_state;
        logic [15:0] lr_cnt;
        logic [7:0] rdata;
        logic status_push;
        logic [7:0] status_data;
        logic selfid_link;
        logic selfid_cont;
    } spb_state_t;

    typedef struct packed {
        logic [11:0] idle_cnt;
        logic sub_gap;
        logic arst_gap;
        logic arb_dly;
    } spb_gt_state_t;
endpackage

// >>> core/spb_gap_timer.sv
// Idle gap timer deriving fair, arbitration reset and arbitration delay gaps
`timescale 1ns/10ps
module spb_gap_timer (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire logic [5:0] gap_i,
    input wire logic idle_i,
    output logic subaction_gap_o,
    output logic arb_reset_gap_o,
    output logic arb_delay_o
);
    spb_pkg::spb_gt_state_t r_reg;
    spb_pkg::spb_gt_state_t r_next;
    logic [11:0] fair_thr;
    logic [11:0] arst_thr;
    logic [11:0] dly_thr;

    assign fair_thr = 12'(spb_pkg::FAIR_BASE + 12'(gap_i) * spb_pkg::FAIR_STEP);
    assign arst_thr = 12'(spb_pkg::ARST_BASE + 12'(gap_i) * spb_pkg::ARST_STEP);
    assign dly_thr = 12'(spb_pkg::DLY_BASE + 12'(gap_i) * spb_pkg::DLY_STEP);

    always_comb begin
        r_next = r_reg;
        if (!idle_i) begin
            r_next.idle_cnt = 12'h000;
        end else if (r_reg.idle_cnt != 12'hFFF) begin
            // Saturate so a long idle never wraps back below a gap
            r_next.idle_cnt = r_reg.idle_cnt + 12'h001;
        end
        r_next.sub_gap = idle_i && (r_reg.idle_cnt >= fair_thr);
        r_next.arst_gap = idle_i && (r_reg.idle_cnt >= arst_thr);
        r_next.arb_dly = idle_i && (r_reg.idle_cnt >= dly_thr);
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r_reg <= '0;
        end else if (ce_i) begin
            r_reg <= r_next;
        end
    end

    assign subaction_gap_o = r_reg.sub_gap;
    assign arb_reset_gap_o = r_reg.arst_gap;
    assign arb_delay_o = r_reg.arb_dly;

    AST_GAP_BUSY_CLEARS: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
        (ce_i && !idle_i) |=> !subaction_gap_o && !arb_reset_gap_o && !arb_delay_o)
        else $error("gap strobe while bus busy");
endmodule

// >>> core/spb_base_fields.sv
// Base configuration and status fields of a three-port serial bus PHY
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
// What this block does
// - Node address read-only, invalid until self-ID
// - Root flag cleared by bus reset, set
// - Cable power bit follows sense input
// - Want-root bit kept across bus resets
// - Long reset request starts 166 us reset
// - Long reset request cleared by resets
// - Gap value scales arbitration gap timings
// - Gap updated by write or config packet
// - Gap reloads 3Fh after reset rules
// - Extended set field reads 111b
// - Port count field reads 3
// - Speed field reads 010b
// - Delay field reads zero
// - Link active resets to one, kept
// - Self-ID bit 9 is link AND power
// - Self-ID bit 20 copies contender
// - Contender loaded from pin at reset
// - Jitter field reads zero
// - Contender pin only input during reset
module spb_base_fields #(
    parameter int unsigned LONG_RESET_CYCLES = spb_pkg::LONG_RESET_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic nrst_i,
    input wire logic ce_i,
    input wire spb_pkg::spb_bus_t reg_bus_i,
    output logic [7:0] reg_rdata_o,
    input wire spb_pkg::spb_core_evt_t core_evt_i,
    input wire logic wire_power_ok_i,
    input wire logic link_power_status_in_i,
    input wire logic contend_or_wake_pin_i,
    output logic contend_or_wake_pin_o,
    output logic contend_or_wake_pin_oe_o,
    input wire logic link_on_req_i,
    output logic [5:0] node_address_o,
    output logic node_address_valid_o,
    output logic root_o,
    output logic want_root_next_o,
    output logic long_bus_reset_o,
    output logic [5:0] gap_count_o,
    output logic subaction_gap_o,
    output logic arb_reset_gap_o,
    output logic arb_delay_o,
    output logic selfid_link_active_o,
    output logic selfid_contender_o,
    output logic status_push_o,
    output logic [7:0] status_data_o
);
    spb_pkg::spb_state_t r_reg;
    spb_pkg::spb_state_t r_next;
    logic [2:0] pin_raw;
    logic [2:0] filt_next;
    logic wr_ctrl;
    logic wr_link;
    logic [7:0] id_word;
    logic [7:0] rd_word;

    assign pin_raw = {contend_or_wake_pin_i, link_power_status_in_i, wire_power_ok_i};
    assign wr_ctrl = reg_bus_i.wr && (reg_bus_i.addr == spb_pkg::REG_CTRL_OFS);
    assign wr_link = reg_bus_i.wr && (reg_bus_i.addr == spb_pkg::REG_LINK_OFS);

    // Pin filter: a change counts once stages two and three agree
    for (genvar i = 0; i < 3; i++) begin : g_pin
        assign filt_next[i] = (r_reg.sync.s2[i] == r_reg.sync.s3[i]) ?
            r_reg.sync.s3[i] : r_reg.sync.filt[i];
    end

    always_comb begin
        id_word = 8'h00;
        id_word[spb_pkg::ID_ADDR_LSB +: 6] = r_reg.node_address;
        id_word[spb_pkg::ID_ROOT_BIT] = r_reg.root;
        id_word[spb_pkg::ID_POWER_BIT] = r_reg.sync.filt[spb_pkg::PIN_POWER];
    end

    always_comb begin
        rd_word = 8'h00;
        case (reg_bus_i.addr)
            spb_pkg::REG_ID_OFS: begin
                rd_word = id_word;
            end
            spb_pkg::REG_CTRL_OFS: begin
                rd_word[spb_pkg::CTRL_ROOTNEXT_BIT] = r_reg.want_root_next;
                rd_word[spb_pkg::CTRL_LONGRST_BIT] = r_reg.long_reset_request;
                rd_word[spb_pkg::CTRL_GAP_LSB +: 6] = r_reg.gap;
            end
            spb_pkg::REG_CAPA_OFS: begin
                rd_word[spb_pkg::CAPA_EXT_LSB +: 3] = spb_pkg::EXT_SET_CODE;
                rd_word[spb_pkg::CAPA_PORTS_LSB +: 4] = spb_pkg::NUM_PORTS_CODE;
            end
            spb_pkg::REG_PHYC_OFS: begin
                rd_word[spb_pkg::PHYC_SPEED_LSB +: 3] = spb_pkg::SPEED_CODE;
                rd_word[spb_pkg::PHYC_DELAY_LSB +: 4] = spb_pkg::DELAY_CODE;
            end
            spb_pkg::REG_LINK_OFS: begin
                rd_word[spb_pkg::LINK_ACTIVE_BIT] = r_reg.link_active;
                rd_word[spb_pkg::LINK_CONT_BIT] = r_reg.contender;
                rd_word[spb_pkg::LINK_JIT_LSB +: 3] = spb_pkg::JITTER_CODE;
            end
            default: begin
                rd_word = 8'h00;
            end
        endcase
    end

    always_comb begin
        r_next = r_reg;
        r_next.sync.s1 = pin_raw;
        r_next.sync.s2 = r_reg.sync.s1;
        r_next.sync.s3 = r_reg.sync.s2;
        r_next.sync.filt = filt_next;
        r_next.status_push = 1'b0;
        r_next.rdata = reg_bus_i.rd ? rd_word : 8'h00;

        if (!r_reg.strap_done) begin
            if (r_reg.strap_cnt != 2'(spb_pkg::STRAP_WAIT)) begin
                r_next.strap_cnt = r_reg.strap_cnt + 2'h1;
            end else if (r_reg.sync.s2[spb_pkg::PIN_CONT] == r_reg.sync.s3[spb_pkg::PIN_CONT]) begin
                r_next.contender = r_reg.sync.s3[spb_pkg::PIN_CONT];
                r_next.strap_done = 1'b1;
            end
        end

        if (core_evt_i.bus_reset) begin
            r_next.addr_valid = 1'b0;
        end
        if (core_evt_i.selfid_done) begin
            r_next.node_address = core_evt_i.node_address;
            r_next.addr_valid = 1'b1;
            r_next.status_push = 1'b1;
            r_next.status_data = id_word;
            r_next.status_data[spb_pkg::ID_ADDR_LSB +: 6] = core_evt_i.node_address;
        end

        if (core_evt_i.bus_reset) begin
            r_next.root = 1'b0;
        end
        if (core_evt_i.tree_root) begin
            r_next.root = 1'b1;
        end

        if (core_evt_i.bus_reset) begin
            r_next.long_reset_request = 1'b0;
        end

        if (core_evt_i.bus_reset) begin
            if (r_reg.gap_reset_seen) begin
                r_next.gap = spb_pkg::GAP_RESET;
            end
            r_next.gap_reset_seen = 1'b1;
        end
        if (core_evt_i.cfg_gap_valid) begin
            r_next.gap = core_evt_i.cfg_gap;
            r_next.gap_reset_seen = 1'b0;
        end

        if (wr_ctrl) begin
            r_next.want_root_next = reg_bus_i.wdata[spb_pkg::CTRL_ROOTNEXT_BIT];
            r_next.long_reset_request = reg_bus_i.wdata[spb_pkg::CTRL_LONGRST_BIT];
            r_next.gap = reg_bus_i.wdata[spb_pkg::CTRL_GAP_LSB +: 6];
            r_next.gap_reset_seen = 1'b0;
        end
        if (wr_link) begin
            r_next.link_active = reg_bus_i.wdata[spb_pkg::LINK_ACTIVE_BIT];
            r_next.contender = reg_bus_i.wdata[spb_pkg::LINK_CONT_BIT];
        end

        case (r_reg.lr_state)
            spb_pkg::LR_IDLE: begin
                if (r_reg.long_reset_request) begin
                    r_next.lr_state = spb_pkg::LR_WAIT;
                end
            end
            spb_pkg::LR_WAIT: begin
                // Traffic in flight finishes before the reset goes out
                if (!r_reg.long_reset_request) begin
                    r_next.lr_state = spb_pkg::LR_IDLE;
                end else if (!core_evt_i.traffic_busy) begin
                    r_next.lr_state = spb_pkg::LR_DRIVE;
                    r_next.lr_cnt = 16'h0000;
                    r_next.long_reset_request = 1'b0;
                end
            end
            spb_pkg::LR_DRIVE: begin
                if (r_reg.lr_cnt == 16'(LONG_RESET_CYCLES - 1)) begin
                    r_next.lr_state = spb_pkg::LR_IDLE;
                end else begin
                    r_next.lr_cnt = r_reg.lr_cnt + 16'h0001;
                end
            end
            default: begin
                r_next.lr_state = spb_pkg::LR_IDLE;
            end
        endcase

        r_next.selfid_link = r_reg.link_active & r_reg.sync.filt[spb_pkg::PIN_LPS];
        r_next.selfid_cont = r_reg.contender;
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r_reg <= '0;
            r_reg.gap <= spb_pkg::GAP_RESET;
            r_reg.link_active <= spb_pkg::LINK_ACTIVE_RESET;
            r_reg.lr_state <= spb_pkg::LR_IDLE;
        end else if (ce_i) begin
            r_reg <= r_next;
        end
    end

    spb_gap_timer u_gap_timer (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .ce_i(ce_i),
        .gap_i(r_reg.gap),
        .idle_i(!core_evt_i.traffic_busy),
        .subaction_gap_o(subaction_gap_o),
        .arb_reset_gap_o(arb_reset_gap_o),
        .arb_delay_o(arb_delay_o)
    );

    assign reg_rdata_o = r_reg.rdata;
    assign node_address_o = r_reg.node_address;
    assign node_address_valid_o = r_reg.addr_valid;
    assign root_o = r_reg.root;
    assign want_root_next_o = r_reg.want_root_next;
    assign long_bus_reset_o = (r_reg.lr_state == spb_pkg::LR_DRIVE);
    assign gap_count_o = r_reg.gap;
    assign selfid_link_active_o = r_reg.selfid_link;
    assign selfid_contender_o = r_reg.selfid_cont;
    assign status_push_o = r_reg.status_push;
    assign status_data_o = r_reg.status_data;
    assign contend_or_wake_pin_oe_o = r_reg.strap_done & link_on_req_i;
    assign contend_or_wake_pin_o = r_reg.strap_done;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!nrst_i);

    AST_ADDR_INVALID: assert property (
        (ce_i && core_evt_i.bus_reset && !core_evt_i.selfid_done) |=> !node_address_valid_o)
        else $error("node address valid after bus reset");
    AST_ROOT_CLEAR: assert property (
        (ce_i && core_evt_i.bus_reset && !core_evt_i.tree_root) |=> !root_o)
        else $error("root flag kept over bus reset");
    AST_POWER_FOLLOW: assert property (
        (ce_i && $stable(wire_power_ok_i))[*5] |=> ce_i [*1] ##0
        (r_reg.sync.filt[spb_pkg::PIN_POWER] == $past(wire_power_ok_i, 5)) or !ce_i)
        else $error("power bit does not follow sense");
    AST_HOLDOFF_KEEP: assert property (
        (ce_i && core_evt_i.bus_reset && !wr_ctrl) |=> $stable(want_root_next_o))
        else $error("want-root bit lost on bus reset");
    AST_LR_DEFER: assert property (
        (ce_i && r_reg.lr_state == spb_pkg::LR_WAIT && core_evt_i.traffic_busy)
        |=> !long_bus_reset_o)
        else $error("long reset started during traffic");
    AST_LR_LENGTH: assert property (
        (ce_i && long_bus_reset_o && r_reg.lr_cnt == 16'(LONG_RESET_CYCLES - 1))
        |=> !long_bus_reset_o)
        else $error("long reset length wrong");
    AST_REQ_CLEAR: assert property (
        (ce_i && core_evt_i.bus_reset && !wr_ctrl) |=> !r_reg.long_reset_request)
        else $error("long reset request survives bus reset");
    AST_GAP_CFG: assert property (
        (ce_i && core_evt_i.cfg_gap_valid && !wr_ctrl)
        |=> gap_count_o == $past(core_evt_i.cfg_gap))
        else $error("config packet gap not taken");
    AST_GAP_RELOAD: assert property (
        (ce_i && core_evt_i.bus_reset && r_reg.gap_reset_seen
        && !wr_ctrl && !core_evt_i.cfg_gap_valid) |=> gap_count_o == spb_pkg::GAP_RESET)
        else $error("gap not reloaded on second bus reset");
    AST_CAPA_READ: assert property (
        (ce_i && reg_bus_i.rd && reg_bus_i.addr == spb_pkg::REG_CAPA_OFS)
        |=> reg_rdata_o == 8'hE3)
        else $error("capability word wrong");
    AST_SPEED_READ: assert property (
        (ce_i && reg_bus_i.rd && reg_bus_i.addr == spb_pkg::REG_PHYC_OFS)
        |=> reg_rdata_o == 8'h40)
        else $error("speed and delay word wrong");
    AST_LINK_KEEP: assert property (
        (ce_i && core_evt_i.bus_reset && !wr_link) |=> $stable(r_reg.link_active))
        else $error("link active changed by bus reset");
    AST_SELFID_LINK: assert property (
        ce_i |=> selfid_link_active_o
        == ($past(r_reg.link_active) & $past(r_reg.sync.filt[spb_pkg::PIN_LPS])))
        else $error("self-ID link bit wrong");
    AST_SELFID_CONT: assert property (
        ce_i |=> selfid_contender_o == $past(r_reg.contender))
        else $error("self-ID contender bit wrong");
    AST_STRAP_NO_DRIVE: assert property (
        !r_reg.strap_done |-> !contend_or_wake_pin_oe_o)
        else $error("strap pin driven before capture");
    AST_RO_IGNORED: assert property (
        (ce_i && reg_bus_i.wr && reg_bus_i.addr == spb_pkg::REG_ID_OFS
        && !core_evt_i.selfid_done && !core_evt_i.bus_reset && !core_evt_i.tree_root)
        |=> $stable(node_address_o) && $stable(root_o))
        else $error("read-only field changed by write");

    COV_LONG_RESET: cover property ($rose(long_bus_reset_o));
    COV_GAP_RELOAD: cover property (core_evt_i.bus_reset && r_reg.gap_reset_seen);
    COV_SELFID: cover property (status_push_o);
    COV_STRAP_SET: cover property ($rose(r_reg.strap_done) && r_reg.contender);
endmodule

// >>> verification/spb_llc_model.sv
// Link layer controller model driving the register port
`timescale 1ns/10ps
module spb_llc_model (
    input wire logic core_clk_i,
    output spb_pkg::spb_bus_t reg_bus_o
);
    logic [7:0] exp_q[$];

    initial begin
        reg_bus_o = '0;
    end

    // Idle bus shows inverted values so stale address or data cannot pass
    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_bus_o <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk_i);
        reg_bus_o <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
    endtask

    // Expected read value is queued for the bench monitor
    task automatic reg_rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge core_clk_i);
        reg_bus_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(e);
        @(posedge core_clk_i);
        reg_bus_o <= '{addr: ~a, wdata: 8'hA5, wr: 1'b0, rd: 1'b0};
    endtask
endmodule

// >>> verification/spb_base_fields_tb_top.sv
// Self-checking bench for the base configuration fields
`timescale 1ns/10ps
module spb_base_fields_tb_top;
    localparam int unsigned LRC = 20;
    logic core_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic pwr = 1'b1;
    logic link_power_status_in = 1'b1;
    logic cpin = 1'b1;
    logic lon = 1'b0;
    logic busy = 1'b0;
    logic rd_seen = 1'b0;
    spb_pkg::spb_bus_t bus;
    spb_pkg::spb_core_evt_t ev = '0;
    spb_pkg::spb_core_evt_t evw;
    logic [7:0] rdata, sdata;
    logic [5:0] node, gap, g, a;
    logic nvalid, root, wroot, lbr, sgap, agap, adly, sl, sc, push, pin_o, pin_oe;
    int errors = 0;
    int n_checks = 0;
    int n_push = 0;
    int cnt, td, tf, ta;

    always #20 core_clk_i = ~core_clk_i;

    always_comb begin
        evw = ev;
        evw.traffic_busy = busy;
    end

    spb_llc_model u_llc (.core_clk_i(core_clk_i), .reg_bus_o(bus));

    spb_base_fields #(.LONG_RESET_CYCLES(LRC)) dut_u (
        .core_clk_i(core_clk_i), .nrst_i(nrst_i), .ce_i(1'b1), .reg_bus_i(bus),
        .reg_rdata_o(rdata), .core_evt_i(evw), .wire_power_ok_i(pwr),
        .link_power_status_in_i(link_power_status_in), .contend_or_wake_pin_i(cpin),
        .contend_or_wake_pin_o(pin_o), .contend_or_wake_pin_oe_o(pin_oe),
        .link_on_req_i(lon), .node_address_o(node), .node_address_valid_o(nvalid),
        .root_o(root), .want_root_next_o(wroot), .long_bus_reset_o(lbr),
        .gap_count_o(gap), .subaction_gap_o(sgap), .arb_reset_gap_o(agap),
        .arb_delay_o(adly), .selfid_link_active_o(sl), .selfid_contender_o(sc),
        .status_push_o(push), .status_data_o(sdata)
    );

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask

    task automatic pulse(input spb_pkg::spb_core_evt_t e);
        @(posedge core_clk_i);
        ev <= e;
        @(posedge core_clk_i);
        ev <= '0;
        tick(2);
    endtask

    // Read data stands only in the cycle after the strobe
    always @(posedge core_clk_i) begin
        if (rd_seen) begin
            chk("rdata", rdata, u_llc.exp_q.pop_front());
        end
        rd_seen <= bus.rd;
        if (push === 1'b1) begin
            n_push++;
        end
    end

    initial begin
        #(40 * 5000);
        errors++;
        finish_test();
    end

    initial begin
        void'($urandom(32'h09bd43ed));
        repeat (2) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        tick(14);
        // Pin change after strap must not reach the contender bit
        @(posedge core_clk_i);
        cpin <= 1'b0;
        u_llc.reg_rd(3'h0, 8'h01);
        u_llc.reg_rd(3'h1, 8'h3F);
        u_llc.reg_rd(3'h2, 8'hE3);
        u_llc.reg_rd(3'h3, 8'h40);
        u_llc.reg_rd(3'h4, 8'hC0);
        for (int i = 5; i < 8; i++) begin
            u_llc.reg_rd(3'(i), 8'h00);
        end
        chk("valid", 8'(nvalid), 8'h00);
        chk("selfid_l", 8'(sl), 8'h01);
        chk("selfid_c", 8'(sc), 8'h01);
        for (int i = 0; i < 4; i++) begin
            if (i != 1) begin
                u_llc.reg_wr(3'(i), 8'hFF);
            end
        end
        u_llc.reg_rd(3'h0, 8'h01);
        u_llc.reg_rd(3'h2, 8'hE3);
        u_llc.reg_rd(3'h3, 8'h40);
        g = 6'($urandom_range(0, 62));
        u_llc.reg_wr(3'h1, {2'b10, g});
        u_llc.reg_rd(3'h1, {2'b10, g});
        tick(1);
        chk("gap", 8'(gap), 8'(g));
        chk("want_root", 8'(wroot), 8'h01);
        pulse('{bus_reset: 1'b1, default: '0});
        u_llc.reg_rd(3'h1, {2'b10, g});
        pulse('{bus_reset: 1'b1, default: '0});
        u_llc.reg_rd(3'h1, 8'hBF);
        g = 6'($urandom_range(0, 62));
        pulse('{cfg_gap_valid: 1'b1, cfg_gap: g, default: '0});
        chk("gap_cfg", 8'(gap), 8'(g));
        pulse('{bus_reset: 1'b1, default: '0});
        chk("gap_keep", 8'(gap), 8'(g));
        a = 6'($urandom);
        pulse('{selfid_done: 1'b1, node_address: a, default: '0});
        chk("node", 8'(node), 8'(a));
        chk("valid", 8'(nvalid), 8'h01);
        chk("n_push", 8'(n_push), 8'h01);
        chk("status", sdata, {a, 2'b01});
        pulse('{tree_root: 1'b1, default: '0});
        @(posedge core_clk_i);
        pwr <= 1'b0;
        tick(10);
        u_llc.reg_rd(3'h0, {a, 2'b10});
        pulse('{bus_reset: 1'b1, default: '0});
        chk("root", 8'(root), 8'h00);
        chk("valid", 8'(nvalid), 8'h00);
        u_llc.reg_wr(3'h4, 8'h40);
        tick(3);
        chk("selfid_l", 8'(sl), 8'h00);
        chk("selfid_c", 8'(sc), 8'h01);
        u_llc.reg_wr(3'h4, 8'hBF);
        @(posedge core_clk_i);
        link_power_status_in <= 1'b0;
        tick(10);
        u_llc.reg_rd(3'h4, 8'h80);
        chk("selfid_l", 8'(sl), 8'h00);
        chk("selfid_c", 8'(sc), 8'h00);
        @(posedge core_clk_i);
        link_power_status_in <= 1'b1;
        tick(10);
        chk("selfid_l", 8'(sl), 8'h01);
        // Long reset held off while traffic runs
        @(posedge core_clk_i);
        busy <= 1'b1;
        u_llc.reg_wr(3'h1, 8'h45);
        tick(6);
        chk("lbr_wait", 8'(lbr), 8'h00);
        u_llc.reg_rd(3'h1, 8'h45);
        @(posedge core_clk_i);
        busy <= 1'b0;
        cnt = 0;
        for (int i = 0; i < 200; i++) begin
            tick(1);
            cnt += int'(lbr === 1'b1);
        end
        chk("lbr_len", 8'(cnt), 8'(LRC));
        u_llc.reg_rd(3'h1, 8'h05);
        @(posedge core_clk_i);
        busy <= 1'b1;
        u_llc.reg_wr(3'h1, 8'h45);
        pulse('{bus_reset: 1'b1, default: '0});
        u_llc.reg_rd(3'h1, 8'h05);
        @(posedge core_clk_i);
        busy <= 1'b0;
        tick(10);
        chk("lbr_none", 8'(lbr), 8'h00);
        // Gap timings compared by spacing, free of start offset
        @(posedge core_clk_i);
        busy <= 1'b1;
        tick(3);
        @(posedge core_clk_i);
        busy <= 1'b0;
        td = -1;
        tf = -1;
        ta = -1;
        for (int i = 0; i < 200; i++) begin
            tick(1);
            if (adly === 1'b1 && td < 0) td = i;
            if (sgap === 1'b1 && tf < 0) tf = i;
            if (agap === 1'b1 && ta < 0) ta = i;
        end
        chk("fair_dly", 8'(tf - td), 8'h07);
        chk("arst_fair", 8'(ta - tf), 8'h0E);
        @(posedge core_clk_i);
        lon <= 1'b1;
        tick(2);
        chk("pin_oe", {pin_oe, pin_o}, 8'h03);
        tick(2);
        finish_test();
    end
endmodule
